// ---- feq_pkg.sv ----
// feq_pkg: register map, field layout, reset values and carrier types
// of the fir equaliser configuration block.
// assumes a 12-bit apb byte address and 8-bit converter samples.
package feq_pkg;
  localparam logic [11:0] FEQ_ADDR_CONFIG = 12'h400;
  localparam logic [11:0] FEQ_ADDR_STATUS = 12'h404;
  localparam logic [11:0] FEQ_ADDR_COEF_A0 = 12'h418;
  localparam logic [11:0] FEQ_ADDR_COEF_B0 = 12'h440;
  localparam logic [7:0] FEQ_CONFIG_RESET = 8'h00;
  localparam logic [15:0] FEQ_COEF_RESET = 16'h0000;
  localparam int FEQ_SHARE_BIT = 6;
  localparam int FEQ_MERGE_BIT = 5;
  localparam int FEQ_WEIGHT_LSB = 2;
  localparam int FEQ_MODE_LSB = 0;
  localparam logic [1:0] FEQ_MODE_DISABLED = 2'h0;
  localparam logic [1:0] FEQ_MODE_ENABLED = 2'h2;
  localparam logic [2:0] FEQ_WEIGHT_MAX = 3'h6;
  localparam int FEQ_WEIGHT_OFFSET = 16;
  localparam logic signed [14:0] FEQ_SAT_HI = 15'sh007f;
  localparam logic signed [14:0] FEQ_SAT_LO = -15'sh0080;

  typedef struct packed {
    logic spare;
    logic share;
    logic merge;
    logic [2:0] weight;
    logic [1:0] mode;
  } feq_config_type;

  typedef struct packed {
    logic valid;
    logic [7:0] a;
    logic [7:0] b;
  } feq_sample_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    feq_config_type cfg;
    logic [15:0] coef_a;
    logic [15:0] coef_b;
    logic [7:0] prev_a;
    logic [7:0] prev_b;
    feq_sample_type out;
  } feq_state_type;
endpackage

// ---- feq_top.sv ----
// feq_top: apb register file and two-channel equaliser tap path.
// assumes samples arrive from logic on i_sys_clk and an apb master on the same clock.
//
// Function
// R1 - share bit set: channel B filter uses channel A coefficients.
// R2 - share bit clear: channel B filter uses its own coefficient set.
// R3 - merge bit set: both filters act as one filter on one sample stream.
// R4 - software sets merge whenever the converter runs single-channel.
// R5 - side weight scales all coefficients except the centre one.
// R6 - side coefficient lsb weight is 2^(weight-16); weights 0 to 6.
// R7 - side weight resets to 0, lsb 2^-16, finest precision.
// R8 - larger weight gives wider coefficient range, coarser precision.
// R9 - mode 0 disables (reset), 2 enables, 1 and 3 reserved.
// R10 - software programs coefficients before using the filter.
// R11 - coefficient A0 register at 0x418, resets to zero.
// R12 - while disabled samples pass unmodified, coefficients have no effect.
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module feq_top
  import feq_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire feq_sample_type i_sample,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  output feq_sample_type o_sample
);

  feq_state_type st;
  feq_state_type next_st;
  logic active;
  logic wr_fire;
  logic mapped;
  logic [15:0] coef_b_eff;
  logic [7:0] prev_for_a;
  logic [7:0] prev_for_b;

  // one tap around a unity centre: x + side term, saturated to 8 bits
  function automatic logic [7:0] fir_tap(input logic [7:0] x, input logic [7:0] xp,
                                         input logic [15:0] c, input logic [2:0] w);
    logic signed [29:0] prod;
    logic signed [29:0] scaled;
    logic signed [13:0] side;
    logic signed [14:0] sum;
    logic [2:0] wc;
    wc = (w > FEQ_WEIGHT_MAX) ? FEQ_WEIGHT_MAX : w; // reserved weights clamp to 6
    prod = 30'(signed'(xp)) * 30'(signed'(c));
    scaled = prod <<< wc; // R6 R8
    side = 14'(scaled >>> FEQ_WEIGHT_OFFSET); // R5 R6
    sum = 15'(signed'(x)) + 15'(side); // centre tap stays unscaled
    if (sum > FEQ_SAT_HI) begin
      fir_tap = 8'(FEQ_SAT_HI);
    end else if (sum < FEQ_SAT_LO) begin
      fir_tap = 8'(FEQ_SAT_LO);
    end else begin
      fir_tap = 8'(sum);
    end
  endfunction

  // decode and tap selection
  always_comb begin
    active = (st.cfg.mode == FEQ_MODE_ENABLED); // R9
    coef_b_eff = st.cfg.share ? st.coef_a : st.coef_b; // R1 R2
    // merged: A and B are consecutive samples of one stream, A first
    prev_for_a = st.prev_b;
    prev_for_b = st.cfg.merge ? i_sample.a : st.prev_b; // R3
    if (!st.cfg.merge) begin
      prev_for_a = st.prev_a;
    end
    wr_fire = i_psel && i_penable && st.pready && i_pwrite;
    mapped = (i_paddr == FEQ_ADDR_CONFIG) || (i_paddr == FEQ_ADDR_STATUS) ||
             (i_paddr == FEQ_ADDR_COEF_A0) || (i_paddr == FEQ_ADDR_COEF_B0);
  end

  // next state: apb slave with one access cycle, then the sample path
  always_comb begin
    next_st = st;
    // pready rises in the access cycle, so read data can come from a flop
    next_st.pready = i_psel && !i_penable;
    next_st.pslverr = i_psel && !i_penable && !mapped;
    if (i_psel && !i_penable) begin
      next_st.prdata = 32'h0000_0000;
      case (i_paddr)
        FEQ_ADDR_CONFIG: next_st.prdata = {24'h00_0000, st.cfg};
        FEQ_ADDR_STATUS: next_st.prdata = {29'h0000_0000, st.cfg.share, st.cfg.merge, active};
        FEQ_ADDR_COEF_A0: next_st.prdata = {16'h0000, st.coef_a};
        FEQ_ADDR_COEF_B0: next_st.prdata = {16'h0000, st.coef_b};
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end
    // writes land on the completing edge only; status is read-only
    if (wr_fire) begin
      case (i_paddr)
        FEQ_ADDR_CONFIG: begin
          if (i_pstrb[0]) begin
            next_st.cfg = i_pwdata[7:0]; // R9
          end
        end
        FEQ_ADDR_COEF_A0: begin
          if (i_pstrb[0]) begin
            next_st.coef_a[7:0] = i_pwdata[7:0]; // R11
          end
          if (i_pstrb[1]) begin
            next_st.coef_a[15:8] = i_pwdata[15:8]; // R11
          end
        end
        FEQ_ADDR_COEF_B0: begin
          if (i_pstrb[0]) begin
            next_st.coef_b[7:0] = i_pwdata[7:0];
          end
          if (i_pstrb[1]) begin
            next_st.coef_b[15:8] = i_pwdata[15:8];
          end
        end
        default: next_st.cfg = st.cfg;
      endcase
    end
    // sample path: history advances on every valid pair
    next_st.out.valid = i_sample.valid;
    if (i_sample.valid) begin
      next_st.prev_a = i_sample.a;
      next_st.prev_b = i_sample.b;
      if (active) begin
        next_st.out.a = fir_tap(i_sample.a, prev_for_a, st.coef_a, st.cfg.weight);
        next_st.out.b = fir_tap(i_sample.b, prev_for_b, coef_b_eff, st.cfg.weight);
      end else begin
        next_st.out.a = i_sample.a; // R12
        next_st.out.b = i_sample.b; // R12
      end
    end
    if (i_reset) begin
      next_st = '0;
      next_st.cfg = FEQ_CONFIG_RESET; // R7 R9
      next_st.coef_a = FEQ_COEF_RESET; // R11
      next_st.coef_b = FEQ_COEF_RESET;
    end
  end

  // single state register; reset is folded into next_st
  always_ff @(posedge i_sys_clk) begin
    st <= next_st;
  end

  assign o_pready = st.pready;
  assign o_pslverr = st.pslverr;
  assign o_prdata = st.prdata;
  assign o_sample = st.out;

  property p_reset_values;
    @(posedge i_sys_clk) i_reset |=> (st.cfg.weight == 3'h0) && (st.cfg.mode == 2'h0)
      && (st.coef_a == 16'h0000);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // R7

  property p_coef_a_write;
    @(posedge i_sys_clk) disable iff (i_reset)
      (wr_fire && i_paddr == FEQ_ADDR_COEF_A0 && i_pstrb[1:0] == 2'h3)
      |=> st.coef_a == $past(i_pwdata[15:0]);
  endproperty
  a_coef_a_write: assert property (p_coef_a_write) else $error("coef A0 not written"); // R11

  property p_disabled_pass;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_sample.valid && st.cfg.mode != FEQ_MODE_ENABLED)
      |=> o_sample.valid && o_sample.a == $past(i_sample.a) && o_sample.b == $past(i_sample.b);
  endproperty
  a_disabled_pass: assert property (p_disabled_pass) else $error("disabled path altered"); // R12

  property p_shared_equal;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_sample.valid && active && st.cfg.share && !st.cfg.merge
       && i_sample.a == i_sample.b && st.prev_a == st.prev_b)
      |=> o_sample.a == o_sample.b;
  endproperty
  a_shared_equal: assert property (p_shared_equal) else $error("shared coefs differ"); // R1

  property p_own_set;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_sample.valid && active && !st.cfg.share && !st.cfg.merge && st.prev_b == 8'h01
       && st.coef_b == 16'h4000 && st.cfg.weight == 3'h2 && $signed(i_sample.b) < 8'sh7f)
      |=> o_sample.b == 8'($past(i_sample.b) + 8'h01);
  endproperty
  a_own_set: assert property (p_own_set) else $error("B not on own coefs"); // R2

  property p_merged;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_sample.valid && active && st.cfg.merge && !st.cfg.share && i_sample.a == 8'h01
       && st.coef_b == 16'h4000 && st.cfg.weight == 3'h2 && $signed(i_sample.b) < 8'sh7f)
      |=> o_sample.b == 8'($past(i_sample.b) + 8'h01);
  endproperty
  a_merged: assert property (p_merged) else $error("merged stream wrong"); // R3

  property p_centre_unscaled;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_sample.valid && active && !st.cfg.merge && st.coef_a == 16'h0000)
      |=> o_sample.a == $past(i_sample.a);
  endproperty
  a_centre_unscaled: assert property (p_centre_unscaled) else $error("centre scaled"); // R5

  property p_weight_step;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_sample.valid && active && !st.cfg.merge && st.prev_a == 8'h01
       && st.coef_a == 16'h4000 && st.cfg.weight == 3'h2 && $signed(i_sample.a) < 8'sh7f)
      |=> o_sample.a == 8'($past(i_sample.a) + 8'h01);
  endproperty
  a_weight_step: assert property (p_weight_step) else $error("side weight wrong"); // R6 R8

  property p_apb_answer;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_psel && !i_penable) |=> o_pready && (o_pslverr == !$past(mapped));
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("apb answer wrong");

  // apb answer: one cycle only, never unasked, error only beside ready
  property p_ready_once;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_pready |=> !o_pready;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready held too long");

  property p_ready_unasked;
    @(posedge i_sys_clk) disable iff (i_reset)
      !i_psel |=> !o_pready && !o_pslverr;
  endproperty
  a_ready_unasked: assert property (p_ready_unasked) else $error("pready without select");

  property p_err_with_ready;
    @(posedge i_sys_clk) disable iff (i_reset)
      o_pslverr |-> o_pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");

  property p_unmapped_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_psel && !i_penable && !mapped) |=> o_prdata == 32'h0000_0000;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  // register file: a read shows the stored value, a write lands on the completing edge
  property p_config_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_psel && !i_penable && i_paddr == FEQ_ADDR_CONFIG)
      |=> o_prdata == {24'h00_0000, st.cfg};
  endproperty
  a_config_read: assert property (p_config_read) else $error("config read wrong"); // R9

  property p_config_write;
    @(posedge i_sys_clk) disable iff (i_reset)
      (wr_fire && i_paddr == FEQ_ADDR_CONFIG && i_pstrb[0])
      |=> st.cfg == $past(i_pwdata[7:0]);
  endproperty
  a_config_write: assert property (p_config_write) else $error("config not written"); // R9

  property p_status_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_psel && !i_penable && i_paddr == FEQ_ADDR_STATUS)
      |=> o_prdata == {29'h0000_0000, st.cfg.share, st.cfg.merge, (st.cfg.mode == FEQ_MODE_ENABLED)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong"); // R9

  property p_coef_a_read;
    @(posedge i_sys_clk) disable iff (i_reset)
      (i_psel && !i_penable && i_paddr == FEQ_ADDR_COEF_A0)
      |=> o_prdata == {16'h0000, st.coef_a};
  endproperty
  a_coef_a_read: assert property (p_coef_a_read) else $error("coef A0 read wrong"); // R11

  property p_coef_b_write;
    @(posedge i_sys_clk) disable iff (i_reset)
      (wr_fire && i_paddr == FEQ_ADDR_COEF_B0 && i_pstrb[1:0] == 2'h3)
      |=> st.coef_b == $past(i_pwdata[15:0]);
  endproperty
  a_coef_b_write: assert property (p_coef_b_write) else $error("coef B0 not written"); // R2

  // status and unmapped writes must leave every register alone
  property p_write_refused;
    @(posedge i_sys_clk) disable iff (i_reset)
      (wr_fire && (i_paddr == FEQ_ADDR_STATUS || !mapped))
      |=> $stable(st.cfg) && $stable(st.coef_a) && $stable(st.coef_b);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("refused write landed");

  // sample path: fixed one-cycle latency, output held between pairs
  property p_valid_follow;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_sample.valid |=> o_sample.valid;
  endproperty
  a_valid_follow: assert property (p_valid_follow) else $error("output valid missing");

  property p_idle_hold;
    @(posedge i_sys_clk) disable iff (i_reset)
      !i_sample.valid |=> !o_sample.valid && $stable(o_sample.a) && $stable(o_sample.b);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle output moved");

  property p_history;
    @(posedge i_sys_clk) disable iff (i_reset)
      i_sample.valid |=> st.prev_a == $past(i_sample.a) && st.prev_b == $past(i_sample.b);
  endproperty
  a_history: assert property (p_history) else $error("sample history lost"); // R3
endmodule

// ---- tb_top.sv ----
// tb_top: self-checking bench for feq_top through apb and the sample port.
// assumes one clock; the bench tracks the expected config, coefficients and history.
`timescale 1ns/1ps
module tb_top
  import feq_pkg::*;
;
  logic i_sys_clk, i_reset, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  feq_sample_type smp, osmp;
  feq_config_type cfg;
  logic [15:0] ca, cb;
  logic [7:0] pa, pb, ea, eb;
  int failures, cmp_count;

  feq_top u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(4'hf), .i_sample(smp), .o_pready(pready), .o_pslverr(pslverr),
    .o_prdata(prdata), .o_sample(osmp));

  // free-running 250 mhz clock
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk("read_data", rd, exp);
    chk("read_err", err, eerr);
  endtask

  task automatic setcfg(input logic s, input logic m, input logic [2:0] w, input logic [1:0] md);
    cfg = '{1'b0, s, m, w, md};
    apb(1'b1, FEQ_ADDR_CONFIG, {24'h0, cfg});
    rdchk(FEQ_ADDR_CONFIG, {24'h0, cfg}, 1'b0);
    rdchk(FEQ_ADDR_STATUS, {29'h0, s, m, md == FEQ_MODE_ENABLED}, 1'b0);
  endtask

  // reference tap: centre at unity, side tap scaled by 2^(weight-16)
  function automatic logic [7:0] filt(logic [7:0] x, logic [7:0] p, logic [15:0] c);
    int t;
    t = (int'($signed(p)) * int'($signed(c))) <<< ((cfg.weight > 3'h6) ? 6 : cfg.weight);
    t = (t >>> 16) + int'($signed(x));
    if (t > 127) t = 127;
    if (t < -128) t = -128;
    return (cfg.mode == FEQ_MODE_ENABLED) ? t[7:0] : x;
  endfunction

  // one sample pair in, its result checked one cycle later
  task automatic send(input logic [7:0] a, input logic [7:0] b);
    ea = filt(a, cfg.merge ? pb : pa, ca);
    eb = filt(b, cfg.merge ? a : pb, cfg.share ? ca : cb);
    pa = a;
    pb = b;
    @(posedge i_sys_clk);
    smp <= '{1'b1, a, b};
    @(posedge i_sys_clk);
    smp.valid <= 1'b0;
    @(posedge i_sys_clk);
    chk("out_valid", osmp.valid, 32'h1);
    chk("out_a", osmp.a, ea);
    chk("out_b", osmp.b, eb);
  endtask

  initial begin
    {i_reset, psel, penable, pwrite, paddr, pwdata, smp} = '0;
    i_reset = 1'b1;
    {cfg, ca, cb, pa, pb} = '0;
    failures = 0;
    cmp_count = 0;
    repeat (20) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rdchk(FEQ_ADDR_CONFIG, 32'h0, 1'b0);
    rdchk(FEQ_ADDR_COEF_A0, 32'h0, 1'b0);
    rdchk(12'h7fc, 32'h0, 1'b1);
    ca = 16'h4000;
    cb = 16'h2000;
    apb(1'b1, FEQ_ADDR_COEF_A0, {16'h0, ca});
    apb(1'b1, FEQ_ADDR_COEF_B0, {16'h0, cb});
    rdchk(FEQ_ADDR_COEF_A0, {16'h0, ca}, 1'b0);
    // legal mode codes only, twice each; reserved codes are never written
    for (int md = 0; md < 4; md++) begin
      setcfg(1'b0, 1'b0, 3'h0, {md[1], 1'b0});
      send(8'h30 + 8'(md), 8'hd0 - 8'(md));
    end
    // weights 0..7 with share and merge toggled along the way
    for (int w = 0; w < 8; w++) begin
      setcfg(w[0], w[1], w[2:0], FEQ_MODE_ENABLED);
      send(8'(8'h25 * w + 8'h13), 8'(8'h9e - 8'h17 * w));
      send(8'h7f, 8'h80);
    end
    // status and unmapped writes must not touch the config register
    apb(1'b1, FEQ_ADDR_STATUS, 32'hffff_ffff);
    chk("status_wr_err", err, 1'b0);
    apb(1'b1, 12'h7fc, 32'hffff_ffff);
    chk("unmapped_wr_err", err, 1'b1);
    rdchk(FEQ_ADDR_CONFIG, {24'h0, cfg}, 1'b0);
    // directed taps: known side terms isolate each coefficient path
    ca = 16'h0000;
    cb = 16'h4000;
    apb(1'b1, FEQ_ADDR_COEF_A0, {16'h0, ca});
    apb(1'b1, FEQ_ADDR_COEF_B0, {16'h0, cb});
    setcfg(1'b0, 1'b0, 3'h2, FEQ_MODE_ENABLED);
    send(8'h01, 8'h01);
    send(8'h20, 8'h21);
    setcfg(1'b0, 1'b1, 3'h2, FEQ_MODE_ENABLED);
    send(8'h01, 8'h30);
    setcfg(1'b1, 1'b0, 3'h2, FEQ_MODE_ENABLED);
    send(8'h01, 8'h01);
    send(8'h42, 8'h42);
    ca = 16'h4000;
    apb(1'b1, FEQ_ADDR_COEF_A0, {16'h0, ca});
    setcfg(1'b0, 1'b0, 3'h2, FEQ_MODE_ENABLED);
    send(8'h01, 8'h00);
    send(8'h10, 8'h00);
    end_of_test();
  end
endmodule
